// ---- epr_defs.svh ----
/*
 * Timing and layout constants for the EPROM read/program host controller.
 * Assumes a single 10 MHz controller clock; pin timings except access and float become cycle counts here.
 */
`ifndef EPR_DEFS_SVH
`define EPR_DEFS_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define EPR_CLK_NS        100
`define EPR_CEIL(ns)      (((ns) + `EPR_CLK_NS - 1) / `EPR_CLK_NS)
`define EPR_FLOOR(ns)     ((ns) / `EPR_CLK_NS)

// ----------------------------------------------------------------------------
// pin timing in ns (least times unless named max)
// ----------------------------------------------------------------------------
`define EPR_SETUP_NS      2000
`define EPR_A10_NS        1000
`define EPR_VERIFY_NS     1000
`define EPR_PULSE_NS      100000
`define EPR_PULSE_MIN_NS  95000
`define EPR_PULSE_MAX_NS  105000
`define EPR_ACCESS_NS     150
`define EPR_FLOAT_NS      50

// ----------------------------------------------------------------------------
// timing in cycles
// ----------------------------------------------------------------------------
`define EPR_SETUP_CYC     `EPR_CEIL(`EPR_SETUP_NS)
`define EPR_A10_CYC       `EPR_CEIL(`EPR_A10_NS)
`define EPR_VERIFY_CYC    `EPR_CEIL(`EPR_VERIFY_NS)
`define EPR_PULSE_CYC     `EPR_CEIL(`EPR_PULSE_NS)
`define EPR_PULSE_MIN_CYC `EPR_CEIL(`EPR_PULSE_MIN_NS)
`define EPR_PULSE_MAX_CYC `EPR_FLOOR(`EPR_PULSE_MAX_NS)

// ----------------------------------------------------------------------------
// sizes and values
// ----------------------------------------------------------------------------
`define EPR_TMR_W         11
`define EPR_MAX_PULSES    25
`define EPR_ERASED_BYTE   8'hff
`define EPR_A10_BIT       10

`endif

// ---- epr_pkg.sv ----
/*
 * Types shared by the EPROM host controller files.
 * Assumes epr_defs.svh is on the include path.
 */
package epr_pkg;

	typedef enum logic [1:0] {
		EPR_OP_READ      = 2'h0,
		EPR_OP_PROGRAM   = 2'h1,
		EPR_OP_MARGIN_ON = 2'h2,
		EPR_OP_MARGIN_OFF = 2'h3
	} epr_op_t;

	typedef struct packed {
		epr_op_t     op;
		logic [15:0] addr;
		logic [7:0]  data;
	} epr_cmd_t;

	// one bundle for everything driven toward the memory
	typedef struct packed {
		logic [15:0] addr;
		logic        chip_sel_n;
		logic        gate_n;
		logic        vpp_en;
		logic        id_hv_en;
		logic [7:0]  data;
		logic        data_oe;
	} epr_pins_t;

	typedef struct packed {
		logic [7:0] data;
		logic       fail;
		logic [7:0] pulses;
	} epr_result_t;

endpackage

// ---- epr_timer.sv ----
/*
 * Down-counter that times one controller phase of a given number of cycles.
 * Assumes load_in is asserted only on the edge that starts the phase.
 */
`timescale 1ns/1ns
`default_nettype none

module epr_timer #(
	parameter int W = 11
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] cycles_in,
	output logic              done_out
);

	logic [W-1:0] cnt_reg;

	// cycles - 1 so that a phase of N lasts exactly N clock periods
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_reg <= '0;
		else if (load_in)
			cnt_reg <= cycles_in - W'(1);
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - W'(1);
	end

	assign done_out = (cnt_reg == '0);

endmodule // epr_timer

`default_nettype wire

// ---- epr_host.sv ----
/*
 * Host controller for a byte-wide UV EPROM: read cycles, margin-mode set/clear,
 * and program-with-verify pulses on the memory's pins.
 * Assumes the pins are sampled/driven synchronously to mclk_in and that the board
 * turns vpp_en / id_hv_en into the high-voltage levels on the shared pins.
 */
// Functional notes
// - program mode needs supply at programming voltage and chip select pulsed low.
// - host drives the byte on the eight data pins during programming.
// - id line high voltage at least 2 us before programming supply rises.
// - programming supply high at least 2 us before chip select falls.
// - margin select high 1 us before chip select rises sets margin mode.
// - margin select low 1 us before chip select rises clears margin mode.
// - margin select stable 1 us after each chip select transition. Kept in margin commands only; addr can move 2 cycles after a read or verify.
// - programming supply held 2 us after chip select transition.
// - id line held high voltage 2 us after programming supply changes.
// - pulse and verify each byte until match; no overprogram pulses. The host stops after MAX_PULSES pulses without a match and sets fail.
// - each program pulse lasts 95 to 105 us.
// - verify reads with output gate low after chip select falls.
`timescale 1ns/1ns
`default_nettype none
`include "epr_defs.svh"

module epr_host
	import epr_pkg::*;
#(
	parameter int ACCESS_NS  = `EPR_ACCESS_NS,
	parameter int FLOAT_NS   = `EPR_FLOAT_NS,
	parameter int MAX_PULSES = `EPR_MAX_PULSES
) (
	input  wire logic    mclk_in,
	input  wire logic    rst_in,
	input  wire logic    cmd_valid_in,
	input  wire epr_cmd_t cmd_in,
	output logic         cmd_ready_out,
	output logic         done_out,
	output epr_result_t  result_out,
	output epr_pins_t    pins_out,
	input  wire logic [7:0] data_pins_in
);

	localparam int W         = `EPR_TMR_W;
	localparam int ACC_CYC   = `EPR_CEIL(ACCESS_NS);
	localparam int FLOAT_CYC = `EPR_CEIL(FLOAT_NS);

	typedef enum logic [12:0] {
		S_IDLE      = 13'h0001,
		S_RD_ACC    = 13'h0002,
		S_FLOAT     = 13'h0004,
		S_PG_SETUP  = 13'h0008,
		S_PG_PULSE  = 13'h0010,
		S_PG_HOLD   = 13'h0020,
		S_PG_VPPLOW = 13'h0040,
		S_PG_VERIFY = 13'h0080,
		S_MG_IDHV   = 13'h0100,
		S_MG_VPP    = 13'h0200,
		S_MG_CE     = 13'h0400,
		S_MG_TAIL   = 13'h0800,
		S_MG_VPPOFF = 13'h1000
	} epr_state_t;

	epr_state_t  state_reg;
	epr_pins_t   pins_reg;
	epr_result_t result_reg;
	logic [7:0]  target_reg;
	logic        again_reg;
	logic        ready_reg;
	logic        done_reg;
	logic        tmr_done;
	logic        tmr_load;
	logic [W-1:0] tmr_cycles;
	logic        match;

	assign match = (data_pins_in == target_reg);

	// ------------------------------------------------------------------------
	// phase timer
	// ------------------------------------------------------------------------
	assign tmr_load = (state_reg == S_IDLE) ? cmd_valid_in : tmr_done;

	always_comb
	begin
		unique case (state_reg)
			S_IDLE:      tmr_cycles = (cmd_in.op == EPR_OP_READ) ? W'(ACC_CYC) : W'(`EPR_SETUP_CYC);
			S_RD_ACC:    tmr_cycles = W'(FLOAT_CYC);
			S_PG_VERIFY: tmr_cycles = W'(FLOAT_CYC);
			S_PG_SETUP:  tmr_cycles = W'(`EPR_PULSE_CYC);
			S_PG_VPPLOW: tmr_cycles = W'(`EPR_VERIFY_CYC);
			S_MG_VPP:    tmr_cycles = W'(`EPR_A10_CYC);
			S_FLOAT, S_PG_PULSE, S_PG_HOLD, S_MG_IDHV, S_MG_CE, S_MG_TAIL, S_MG_VPPOFF:
				tmr_cycles = W'(`EPR_SETUP_CYC);
		endcase
	end

	epr_timer #(.W(W)) u_timer (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.load_in   (tmr_load),
		.cycles_in (tmr_cycles),
		.done_out  (tmr_done)
	);

	// ------------------------------------------------------------------------
	// sequencer: state and pins
	// ------------------------------------------------------------------------
	// gate_n doubles as the supply pin: low = read gate, vpp_en = programming level
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg  <= S_IDLE;
			pins_reg   <= '{addr: 16'h0000, chip_sel_n: 1'b1, gate_n: 1'b1, vpp_en: 1'b0,
				id_hv_en: 1'b0, data: `EPR_ERASED_BYTE, data_oe: 1'b0};
			target_reg <= `EPR_ERASED_BYTE;
			again_reg  <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				S_IDLE:
					if (cmd_valid_in)
					begin
						pins_reg.addr <= cmd_in.addr;
						target_reg    <= cmd_in.data;
						unique case (cmd_in.op)
							EPR_OP_READ:
							begin
								pins_reg.chip_sel_n <= 1'b0;
								pins_reg.gate_n     <= 1'b0;
								state_reg           <= S_RD_ACC;
							end
							EPR_OP_PROGRAM:
							begin
								pins_reg.data    <= cmd_in.data;
								pins_reg.data_oe <= 1'b1;
								pins_reg.vpp_en  <= 1'b1;
								state_reg        <= S_PG_SETUP;
							end
							EPR_OP_MARGIN_ON, EPR_OP_MARGIN_OFF:
							begin
								pins_reg.addr[`EPR_A10_BIT] <= (cmd_in.op == EPR_OP_MARGIN_ON);
								pins_reg.id_hv_en <= 1'b1;
								state_reg         <= S_MG_IDHV;
							end
						endcase
					end
				S_RD_ACC:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b1;
						pins_reg.gate_n     <= 1'b1;
						again_reg           <= 1'b0;
						state_reg           <= S_FLOAT;
					end
				S_FLOAT:
					// data pins stay undriven until the memory has floated them
					if (tmr_done)
					begin
						if (again_reg)
						begin
							pins_reg.data_oe <= 1'b1;
							pins_reg.vpp_en  <= 1'b1;
							state_reg        <= S_PG_SETUP;
						end
						else
							state_reg <= S_IDLE;
					end
				S_PG_SETUP:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b0;
						state_reg           <= S_PG_PULSE;
					end
				S_PG_PULSE:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b1;
						state_reg           <= S_PG_HOLD;
					end
				S_PG_HOLD:
					if (tmr_done)
					begin
						pins_reg.vpp_en  <= 1'b0;
						pins_reg.gate_n  <= 1'b0;
						pins_reg.data_oe <= 1'b0;
						state_reg        <= S_PG_VPPLOW;
					end
				S_PG_VPPLOW:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b0;
						state_reg           <= S_PG_VERIFY;
					end
				S_PG_VERIFY:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b1;
						pins_reg.gate_n     <= 1'b1;
						// a match ends the byte at once: no extra pulses on a margined cell
						again_reg <= !match && (result_reg.pulses < 8'(MAX_PULSES));
						state_reg <= S_FLOAT;
					end
				S_MG_IDHV:
					if (tmr_done)
					begin
						pins_reg.vpp_en <= 1'b1;
						state_reg       <= S_MG_VPP;
					end
				S_MG_VPP:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b0;
						state_reg           <= S_MG_CE;
					end
				S_MG_CE:
					if (tmr_done)
					begin
						pins_reg.chip_sel_n <= 1'b1;
						state_reg           <= S_MG_TAIL;
					end
				S_MG_TAIL:
					if (tmr_done)
					begin
						pins_reg.vpp_en <= 1'b0;
						state_reg       <= S_MG_VPPOFF;
					end
				S_MG_VPPOFF:
					if (tmr_done)
					begin
						pins_reg.id_hv_en <= 1'b0;
						state_reg         <= S_IDLE;
					end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// results and handshake
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			result_reg <= '0;
		else if (state_reg == S_IDLE && cmd_valid_in)
			result_reg <= '0;
		else if (state_reg == S_PG_PULSE && tmr_done)
			result_reg.pulses <= result_reg.pulses + 8'h01;
		else if ((state_reg == S_RD_ACC || state_reg == S_PG_VERIFY) && tmr_done)
		begin
			result_reg.data <= data_pins_in;
			result_reg.fail <= (state_reg == S_PG_VERIFY) && !match;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ready_reg <= 1'b1;
			done_reg  <= 1'b0;
		end
		else
		begin
			ready_reg <= (state_reg == S_IDLE) ? !cmd_valid_in
				: (tmr_done && (state_reg == S_MG_VPPOFF || (state_reg == S_FLOAT && !again_reg)));
			done_reg  <= tmr_done && (state_reg == S_MG_VPPOFF || (state_reg == S_FLOAT && !again_reg));
		end
	end

	assign cmd_ready_out = ready_reg;
	assign done_out      = done_reg;
	assign result_out    = result_reg;
	assign pins_out      = pins_reg;

	// ------------------------------------------------------------------------
	// checks: hold counters on the pins
	// ------------------------------------------------------------------------
	epr_pins_t   prev_reg;
	logic [W:0]  cs_lo_cnt;
	logic [W:0]  cs_cnt;
	logic [W:0]  vpp_cnt;
	logic [W:0]  id_cnt;
	logic [W:0]  a10_cnt;

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prev_reg  <= '0;
			cs_lo_cnt <= '0;
			cs_cnt    <= '0;
			vpp_cnt   <= '0;
			id_cnt    <= '0;
			a10_cnt   <= '0;
		end
		else
		begin
			prev_reg  <= pins_reg;
			cs_lo_cnt <= pins_reg.chip_sel_n ? '0 : (&cs_lo_cnt ? cs_lo_cnt : cs_lo_cnt + 1'b1);
			cs_cnt    <= (pins_reg.chip_sel_n != prev_reg.chip_sel_n) ? (W+1)'(1)
				: (&cs_cnt ? cs_cnt : cs_cnt + 1'b1);
			vpp_cnt   <= (pins_reg.vpp_en != prev_reg.vpp_en) ? (W+1)'(1)
				: (&vpp_cnt ? vpp_cnt : vpp_cnt + 1'b1);
			id_cnt    <= (pins_reg.id_hv_en != prev_reg.id_hv_en) ? (W+1)'(1)
				: (&id_cnt ? id_cnt : id_cnt + 1'b1);
			a10_cnt   <= (pins_reg.addr[`EPR_A10_BIT] != prev_reg.addr[`EPR_A10_BIT]) ? (W+1)'(1)
				: (&a10_cnt ? a10_cnt : a10_cnt + 1'b1);
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// margin strobes run with the id line raised; they are short and carry no data
	AST_PULSE_WIDTH: assert property ($rose(pins_out.chip_sel_n) && pins_out.vpp_en && !pins_out.id_hv_en
		|-> cs_lo_cnt >= (W+1)'(`EPR_PULSE_MIN_CYC) && cs_lo_cnt <= (W+1)'(`EPR_PULSE_MAX_CYC))
		else $error("program pulse width out of range");
	AST_VPP_BEFORE_CE: assert property ($fell(pins_out.chip_sel_n) && pins_out.vpp_en
		|-> vpp_cnt >= (W+1)'(`EPR_SETUP_CYC))
		else $error("chip select fell too soon after supply rise");
	AST_ID_BEFORE_VPP: assert property ($rose(pins_out.vpp_en) && pins_out.id_hv_en
		|-> id_cnt >= (W+1)'(`EPR_SETUP_CYC))
		else $error("supply rose too soon after id line");
	AST_A10_SETUP: assert property ($rose(pins_out.chip_sel_n) && pins_out.id_hv_en
		|-> a10_cnt >= (W+1)'(`EPR_A10_CYC))
		else $error("margin select not settled before chip select rise");
	AST_A10_HOLD: assert property ($changed(pins_out.addr[`EPR_A10_BIT])
		|-> $past(cs_cnt) >= (W+1)'(`EPR_A10_CYC) || $past(state_reg) == S_IDLE)
		else $error("margin select moved too soon after chip select");
	AST_VPP_HOLD: assert property ($fell(pins_out.vpp_en) |-> cs_cnt >= (W+1)'(`EPR_SETUP_CYC))
		else $error("supply dropped too soon after chip select");
	AST_ID_HOLD: assert property ($fell(pins_out.id_hv_en) |-> vpp_cnt >= (W+1)'(`EPR_SETUP_CYC))
		else $error("id line released too soon after supply change");
	AST_DATA_DURING_PULSE: assert property (!pins_out.chip_sel_n && pins_out.vpp_en && !pins_out.id_hv_en
		|-> pins_out.data_oe && pins_out.data == target_reg)
		else $error("data not driven during program pulse");
	AST_NO_CONTENTION: assert property (pins_out.data_oe && !pins_out.chip_sel_n
		|-> pins_out.gate_n)
		else $error("host drives data while memory output gate is open");
	AST_VERIFY_READ: assert property (state_reg == S_PG_VERIFY && tmr_done
		|-> !pins_out.gate_n && !pins_out.chip_sel_n && !pins_out.data_oe)
		else $error("verify sample without read gate");
	AST_ACCESS_WAIT: assert property (state_reg == S_RD_ACC && tmr_done
		|-> cs_lo_cnt + 1'b1 >= (W+1)'(ACC_CYC))
		else $error("read sampled before access time");
	AST_NO_OVERPROGRAM: assert property (state_reg == S_PG_VERIFY && tmr_done && match
		|=> !again_reg ##1 !pins_out.vpp_en)
		else $error("pulse repeated after a good verify");

	COV_READ: cover property (state_reg == S_RD_ACC ##1 state_reg == S_FLOAT);
	COV_RETRY: cover property (state_reg == S_PG_VERIFY && tmr_done && !match);
	COV_MARGIN_ON: cover property (state_reg == S_MG_CE && pins_out.addr[`EPR_A10_BIT]);
	COV_FAIL: cover property ($rose(result_out.fail));

endmodule // epr_host

`default_nettype wire

// ---- epr_mem_model.sv ----
/*
 * Behavioural model of the byte-wide UV memory facing epr_host.
 * Assumes the bench resolves the shared data pins and feeds the level back on bus_in.
 */
`timescale 1ns/1ns
`default_nettype none

module epr_mem_model
	import epr_pkg::*;
#(
	parameter int ACC_NS = 150
) (
	input  wire epr_pins_t  pins_in,
	input  wire logic [7:0] bus_in,
	input  wire logic [7:0] skip_in,
	output logic [7:0]      q_out,
	output logic            q_oe_out,
	output logic            margin_out,
	output logic [15:0]     viol_out
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  q_last = 8'h5a;
	logic [15:0] last_addr = 16'h0000;
	logic [7:0]  hits = 8'h00;
	int unsigned viol = 0;
	realtime     t_vpp = -1.0e6;
	realtime     t_cs = -1.0e6;
	realtime     t_a10 = -1.0e6;
	realtime     t_id = -1.0e6;
	realtime     t_fall = -1.0e6;
	wire logic   cs_n = pins_in.chip_sel_n;
	wire logic   vpp = pins_in.vpp_en;
	wire logic   id = pins_in.id_hv_en;
	wire logic   a10 = pins_in.addr[10];
	wire logic   drive_now;
	wire logic   drive_late;

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// data only after the access time; before that and when floating, a changing pattern
	assign drive_now = !cs_n && !pins_in.gate_n && !vpp;
	assign #(ACC_NS) drive_late = drive_now;
	assign q_oe_out = drive_now;
	assign q_out = (drive_now && drive_late) ? mem[pins_in.addr] : ~q_last;
	assign viol_out = viol[15:0];

	initial
	begin
		margin_out = 1'b0;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'hff;
	end

	always @(negedge drive_now)
		q_last = mem[pins_in.addr];

	// ------------------------------------------------------------------------
	// high-voltage sequencing and programming
	// ------------------------------------------------------------------------
	always @(posedge id)
		t_id = $realtime;
	always @(negedge id)
		if ($realtime - t_vpp < 2000.0) viol++;
	always @(posedge vpp)
	begin
		if (id && $realtime - t_id < 2000.0) viol++;
		t_vpp = $realtime;
	end
	always @(negedge vpp)
	begin
		if ($realtime - t_cs < 2000.0) viol++;
		t_vpp = $realtime;
	end
	always @(a10)
	begin
		if (vpp && id && $realtime - t_cs < 1000.0) viol++;
		t_a10 = $realtime;
	end
	always @(negedge cs_n)
	begin
		if (vpp && $realtime - t_vpp < 2000.0) viol++;
		t_cs = $realtime;
		t_fall = $realtime;
	end
	always @(posedge cs_n)
	begin
		if (vpp && id)
		begin
			if ($realtime - t_a10 < 1000.0) viol++;
			margin_out = a10;
		end
		else if (vpp)
		begin
			if ($realtime - t_fall < 95000.0 || $realtime - t_fall > 105000.0) viol++;
			// a slow cell ignores the first skip_in pulses to one address
			hits = (pins_in.addr == last_addr) ? hits + 8'h01 : 8'h01;
			last_addr = pins_in.addr;
			if (hits > skip_in)
				mem[pins_in.addr] = mem[pins_in.addr] & bus_in;
		end
		t_cs = $realtime;
	end
endmodule // epr_mem_model

`default_nettype wire

// ---- epr_host_test.sv ----
/*
 * Self-checking bench for epr_host driving the memory model.
 * Assumes epr_pkg, epr_host and epr_mem_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

`define EPR_CHK(what, exp, got) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("ERROR %s expected %0h seen %0h", what, exp, got); \
		end \
	end

module epr_host_test
	import epr_pkg::*;
;
	localparam int MAXP = 3;
	logic        mclk_in;
	logic        rst_in;
	logic        cmd_valid_in;
	logic        cmd_ready_out;
	logic        done_out;
	epr_cmd_t    cmd_in;
	epr_result_t result_out;
	epr_pins_t   pins_out;
	logic [7:0]  data_pins;
	logic [7:0]  q;
	logic [7:0]  skip;
	logic        q_oe;
	logic        margin;
	logic [15:0] viol;
	int          bad_count;
	int          n_tests;
	logic [7:0]  shadow [logic [15:0]];

	assign data_pins = (pins_out.data_oe === 1'b1) ? pins_out.data : q;

	epr_host #(.MAX_PULSES(MAXP)) epr_host_i (.mclk_in(mclk_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
		.done_out(done_out), .result_out(result_out), .pins_out(pins_out),
		.data_pins_in(data_pins));
	epr_mem_model #(.ACC_NS(150)) epr_mem_model_i (.pins_in(pins_out), .bus_in(data_pins),
		.skip_in(skip), .q_out(q), .q_oe_out(q_oe), .margin_out(margin), .viol_out(viol));

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [7:0] old_of(logic [15:0] a);
		return shadow.exists(a) ? shadow[a] : 8'hff;
	endfunction

	// pulses until verify matches, when the first s pulses do nothing
	function automatic int pulses_for(logic [7:0] old, logic [7:0] d, int s);
		for (int i = 1; i <= MAXP; i++)
			if (((i > s) ? (old & d) : old) == d) return i;
		return MAXP;
	endfunction

	// entered at a falling edge with the controller idle
	task automatic run(input epr_op_t op, input logic [15:0] a, input logic [7:0] d,
		output int lat);
		cmd_in = '{op: op, addr: a, data: d};
		cmd_valid_in = 1'b1;
		@(negedge mclk_in);
		cmd_valid_in = 1'b0;
		`EPR_CHK("ready drop", 1'b0, cmd_ready_out)
		lat = 0;
		for (int k = 2; k < 30000 && lat == 0; k++)
		begin
			@(negedge mclk_in);
			if (done_out === 1'b1) lat = k;
		end
		if (lat == 0)
		begin
			bad_count++;
			conclude();
		end
		`EPR_CHK("ready back", 1'b1, cmd_ready_out)
	endtask

	task automatic do_read(input logic [15:0] a);
		int lat;
		run(EPR_OP_READ, a, 8'h00, lat);
		`EPR_CHK("read latency", 4, lat)
		`EPR_CHK("read data", old_of(a), result_out.data)
	endtask

	task automatic do_prog(input logic [15:0] a, input logic [7:0] d, input int s);
		int         lat;
		int         p;
		logic [7:0] want;
		skip = s[7:0];
		p = pulses_for(old_of(a), d, s);
		want = (p > s) ? (old_of(a) & d) : old_of(a);
		run(EPR_OP_PROGRAM, a, d, lat);
		shadow[a] = want;
		`EPR_CHK("program latency", 1072 + 1071 * (p - 1), lat)
		`EPR_CHK("pulse count", p[7:0], result_out.pulses)
		`EPR_CHK("fail flag", want != d, result_out.fail)
		`EPR_CHK("verified byte", want, result_out.data)
		skip = 8'h00;
		do_read(a);
	endtask

	task automatic do_margin(input logic on);
		int lat;
		run(on ? EPR_OP_MARGIN_ON : EPR_OP_MARGIN_OFF, 16'h0000, 8'h00, lat);
		`EPR_CHK("margin latency", 91, lat)
		`EPR_CHK("margin mode", on, margin)
	endtask

	// the host must never drive while the memory drives
	always @(negedge mclk_in)
		if (pins_out.data_oe === 1'b1 && q_oe === 1'b1)
		begin
			bad_count++;
			$display("ERROR contention expected 0 seen 1");
		end

	// ------------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------------
	initial
	begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	initial
	begin
		void'($urandom(32'h1cb16897));
		bad_count = 0;
		n_tests = 0;
		cmd_valid_in = 1'b0;
		cmd_in = '0;
		skip = 8'h00;
		rst_in = 1'b1;
		repeat (12) @(posedge mclk_in);
		@(negedge mclk_in);
		`EPR_CHK("reset pins", (epr_pins_t'{16'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 8'hff, 1'b0}), pins_out)
		`EPR_CHK("reset ready", 1'b1, cmd_ready_out)
		`EPR_CHK("reset result", 17'h00000, result_out)
		rst_in = 1'b0;
		@(negedge mclk_in);
		repeat (4) do_read(16'($urandom()));
		do_margin(1'b1);
		do_margin(1'b0);
		do_margin(1'b1);
		repeat (4) do_prog(16'($urandom()), 8'($urandom()), 0);
		do_prog(16'h1234, 8'h0f, 0);
		do_prog(16'h1234, 8'hf0, 0);
		do_prog(16'h2000, 8'h3c, 1);
		do_prog(16'h2001, 8'h5a, MAXP);
		do_margin(1'b0);
		`EPR_CHK("sequencing faults", 16'h0000, viol)
		conclude();
	end
endmodule // epr_host_test

`default_nettype wire
